// *** hw/cgl_pkg.sv ***
package cgl_pkg;
  // list geometry
  localparam int LIST_DEPTH = 1024;
  localparam int PTR_W = 10;
  localparam int LEN_W = 11;
  // entry layout: chan[5:0], gain[7:6], inhibit[8], dyn out[9]
  localparam int CHAN_W = 6;
  localparam int GAIN_W = 2;
  localparam int ENTRY_W = 10;
  localparam int E_CHAN_LSB = 0;
  localparam int E_GAIN_LSB = 6;
  localparam int E_INH_BIT = 8;
  localparam int E_DOUT_BIT = 9;
  // sources
  localparam int NUM_SE_DEFAULT = 32;
  localparam int DIN_W = 16;
  localparam int NUM_CT = 5;
  localparam int CT_W = 32;
  localparam int SAMPLE_W = 16;
  localparam int RES_DEFAULT = 16;
  // aggregate pacing: least spacing between samples rounds up
  localparam int CLK_HZ = 40000000;
  localparam int AGG_RATE_SPS = 500000;
  localparam int PACE_CYC = (CLK_HZ + AGG_RATE_SPS - 1) / AGG_RATE_SPS;
  localparam int PACE_W = 7;
  // reset values
  localparam logic DYN_DOUT_RST = 1'b0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAIT_TRIG = 3'b001,
    ST_READ = 3'b010,
    ST_PACE = 3'b011,
    ST_CONV = 3'b100
  } seq_state_e;

  typedef enum logic [1:0] {
    SRC_ANALOG = 2'b00,
    SRC_DIGITAL = 2'b01,
    SRC_COUNTER = 2'b10,
    SRC_NONE = 2'b11
  } src_kind_e;
endpackage

// *** hw/cgl_list_mem.sv ***
`timescale 1ns/10ps
`default_nettype none
module cgl_list_mem #(
  parameter int DEPTH = 1024,
  parameter int AW = 10,
  parameter int DW = 10
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);
  logic [DW-1:0] mem [DEPTH];
  logic [DW-1:0] rd_data_next;

  // read data always one cycle behind the address
  always_comb begin
    rd_data_next = mem[rd_addr];
  end

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rd_data <= '0;
    end else begin
      rd_data <= rd_data_next;
    end
  end
endmodule
`default_nettype wire

// *** hw/ai_channel_gain_list_sequencer.sv ***
// Summary of operation
// [RULE1] list holds up to 1,024 entries
// [RULE2] scan entries in order, first to last
// [RULE3] any channel order, repeats, single entry allowed
// [RULE4] per-entry inhibit flag discards the sample
// [RULE5] channels 0-31 single-ended, 0-15 differential
// [RULE6] channel 16/32 captures the digital port; code uses channel 32 in both modes
// [RULE7] digital entry anywhere, captured every time
// [RULE8] digital entry paced like analog entries
// [RULE9] software puts threshold channel first
// [RULE10] aggregate 500 kS/s shared by entries
// [RULE11] resolution fixed per build, 12 or 16
// [RULE12] software selects single-ended or differential
// [RULE13] single-value read of one named channel
// [RULE14] low half latches full 32-bit count
// [RULE15] dynamic output follows per-entry bit
// [RULE16] continuous scan wraps to first entry
`timescale 1ns/10ps
`default_nettype none
module ai_channel_gain_list_sequencer
  import cgl_pkg::*;
#(
  parameter int NUM_SE = cgl_pkg::NUM_SE_DEFAULT,
  parameter int RES_BITS = cgl_pkg::RES_DEFAULT
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic list_wr,
  input wire logic [cgl_pkg::PTR_W-1:0] list_addr,
  input wire logic [cgl_pkg::CHAN_W-1:0] list_chan,
  input wire logic [cgl_pkg::GAIN_W-1:0] list_gain,
  input wire logic list_inhibit,
  input wire logic list_dout,
  input wire logic [cgl_pkg::LEN_W-1:0] list_len,
  input wire logic diff_mode,
  input wire logic cont_mode,
  input wire logic dyn_dout_en,
  input wire logic scan_start,
  input wire logic scan_stop,
  input wire logic trig_in,
  input wire logic single_req,
  input wire logic [cgl_pkg::CHAN_W-1:0] single_chan,
  input wire logic [cgl_pkg::GAIN_W-1:0] single_gain,
  input wire logic [cgl_pkg::DIN_W-1:0] din,
  input wire logic [cgl_pkg::NUM_CT*cgl_pkg::CT_W-1:0] ct_count,
  output logic [cgl_pkg::CHAN_W-1:0] mux_chan,
  output logic [cgl_pkg::GAIN_W-1:0] mux_gain,
  output logic mux_diff,
  output logic conv_start,
  input wire logic conv_done,
  input wire logic [RES_BITS-1:0] conv_data,
  output logic sample_valid,
  output logic [cgl_pkg::SAMPLE_W-1:0] sample_data,
  output logic [cgl_pkg::CHAN_W-1:0] sample_chan,
  output logic sample_last,
  output logic busy,
  output logic dyn_dout
);
  import cgl_pkg::*;

  localparam logic [CHAN_W-1:0] SE_LIM = CHAN_W'(NUM_SE);
  localparam logic [CHAN_W-1:0] DIFF_LIM = CHAN_W'(NUM_SE / 2);
  localparam logic [CHAN_W-1:0] CT_TOP = CHAN_W'(NUM_SE + 2 * NUM_CT);
  localparam logic [PACE_W-1:0] PACE_RELOAD = PACE_W'(PACE_CYC - 1);

  // classify a channel number against the active configuration
  function automatic src_kind_e kind_of(input logic [CHAN_W-1:0] ch,
                                        input logic diff);
    src_kind_e k;
    k = SRC_NONE;
    if (diff ? (ch < DIFF_LIM) : (ch < SE_LIM)) begin
      k = SRC_ANALOG; // [RULE5]
    end else if (ch == SE_LIM) begin
      k = SRC_DIGITAL; // [RULE6]
    end else if (ch > SE_LIM && ch <= CT_TOP) begin
      k = SRC_COUNTER;
    end
    return k;
  endfunction

  // offset of a counter channel: bit 0 picks the half, the rest the counter
  function automatic logic [CHAN_W-1:0] ct_off(input logic [CHAN_W-1:0] ch);
    return ch - SE_LIM - CHAN_W'(1);
  endfunction

  logic [ENTRY_W-1:0] rd_entry;
  logic [ENTRY_W-1:0] wr_entry;
  seq_state_e state_reg, state_next, after_reg, after_next;
  logic [PTR_W-1:0] ptr_reg, ptr_next;
  logic [PACE_W-1:0] pace_reg, pace_next;
  logic single_reg, single_next;
  logic [CHAN_W-1:0] s_chan_reg, s_chan_next;
  logic [GAIN_W-1:0] s_gain_reg, s_gain_next;
  logic inh_reg, inh_next, last_reg, last_next;
  logic [CHAN_W-1:0] mux_chan_next;
  logic [GAIN_W-1:0] mux_gain_next;
  logic mux_diff_next, conv_start_next, dyn_dout_next;
  logic sample_valid_next, sample_last_next;
  logic [SAMPLE_W-1:0] sample_data_next;
  logic [CHAN_W-1:0] sample_chan_next;
  logic [CT_W-1:0] ct_latch_reg [NUM_CT];
  logic [CT_W-1:0] ct_latch_next [NUM_CT];
  logic [DIN_W-1:0] din_s1_reg, din_s2_reg;
  logic trig_s1_reg, trig_s2_reg, trig_prev_reg;
  logic trig_rise;
  logic [CHAN_W-1:0] cur_chan, off;
  logic [GAIN_W-1:0] cur_gain;
  logic cur_inh, cur_dout, is_last;
  src_kind_e cur_kind;

  assign wr_entry = {list_dout, list_inhibit, list_gain, list_chan};

  // list storage; entries kept exactly as written [RULE1] [RULE3]
  cgl_list_mem #(
    .DEPTH(LIST_DEPTH),
    .AW(PTR_W),
    .DW(ENTRY_W)
  ) u_list (
    .clk(clk),
    .rstn(rstn),
    .wr_en(list_wr),
    .wr_addr(list_addr),
    .wr_data(wr_entry),
    .rd_addr(ptr_reg),
    .rd_data(rd_entry)
  );

  // pin inputs pass two flops; edge detect looks only at the second
  always_ff @(posedge clk) begin
    if (!rstn) begin
      din_s1_reg <= '0;
      din_s2_reg <= '0;
      trig_s1_reg <= 1'b0;
      trig_s2_reg <= 1'b0;
      trig_prev_reg <= 1'b0;
    end else begin
      din_s1_reg <= din;
      din_s2_reg <= din_s1_reg;
      trig_s1_reg <= trig_in;
      trig_s2_reg <= trig_s1_reg;
      trig_prev_reg <= trig_s2_reg;
    end
  end

  assign trig_rise = trig_s2_reg & ~trig_prev_reg;

  // current entry: list word, or the directly named channel
  always_comb begin
    cur_chan = single_reg ? s_chan_reg : rd_entry[E_CHAN_LSB +: CHAN_W];
    cur_gain = single_reg ? s_gain_reg : rd_entry[E_GAIN_LSB +: GAIN_W];
    cur_inh = single_reg ? 1'b0 : rd_entry[E_INH_BIT];
    cur_dout = rd_entry[E_DOUT_BIT];
    cur_kind = kind_of(cur_chan, diff_mode);
    off = ct_off(cur_chan);
    // a zero length is taken as one entry
    is_last = ({1'b0, ptr_reg} + LEN_W'(1) >= list_len);
  end

  // sequencer next state
  always_comb begin
    state_next = state_reg;
    after_next = after_reg;
    ptr_next = ptr_reg;
    pace_next = (pace_reg != '0) ? pace_reg - PACE_W'(1) : pace_reg;
    single_next = single_reg;
    s_chan_next = s_chan_reg;
    s_gain_next = s_gain_reg;
    inh_next = inh_reg;
    last_next = last_reg;
    mux_chan_next = mux_chan;
    mux_gain_next = mux_gain;
    mux_diff_next = diff_mode; // [RULE12]
    conv_start_next = 1'b0;
    dyn_dout_next = dyn_dout;
    sample_valid_next = 1'b0;
    sample_last_next = 1'b0;
    sample_data_next = sample_data;
    sample_chan_next = sample_chan;
    for (int i = 0; i < NUM_CT; i++) begin
      ct_latch_next[i] = ct_latch_reg[i];
    end
    case (state_reg)
      ST_IDLE: begin
        if (scan_start) begin
          ptr_next = '0; // [RULE2]
          single_next = 1'b0;
          state_next = cont_mode ? ST_READ : ST_WAIT_TRIG;
        end else if (single_req) begin
          single_next = 1'b1; // [RULE13]
          s_chan_next = single_chan;
          s_gain_next = single_gain;
          state_next = ST_PACE;
        end
      end
      ST_WAIT_TRIG: begin
        // each trigger runs one pass of the list
        if (trig_rise) begin
          ptr_next = '0;
          state_next = ST_READ;
        end
      end
      ST_READ: begin
        // address settles; entry readable next cycle
        state_next = ST_PACE;
      end
      ST_PACE: begin
        // every entry kind waits for the shared sample slot [RULE8]
        if (pace_reg == '0) begin
          pace_next = PACE_RELOAD; // [RULE10]
          mux_chan_next = cur_chan;
          mux_gain_next = cur_gain;
          if (dyn_dout_en && !single_reg) begin
            dyn_dout_next = cur_dout; // [RULE15]
          end
          inh_next = cur_inh;
          last_next = is_last && !single_reg;
          sample_chan_next = cur_chan;
          if (single_reg) begin
            after_next = ST_IDLE;
          end else if (is_last) begin
            ptr_next = '0;
            after_next = cont_mode ? ST_READ : ST_WAIT_TRIG; // [RULE16]
          end else begin
            ptr_next = ptr_reg + PTR_W'(1); // [RULE2]
            after_next = ST_READ;
          end
          if (cur_kind == SRC_ANALOG) begin
            conv_start_next = 1'b1;
            state_next = ST_CONV;
          end else begin
            // immediate captures need no converter
            sample_valid_next = ~cur_inh; // [RULE4]
            sample_last_next = is_last && !single_reg;
            sample_data_next = '0;
            if (cur_kind == SRC_DIGITAL) begin
              sample_data_next = din_s2_reg; // [RULE6] [RULE7]
            end else if (cur_kind == SRC_COUNTER) begin
              if (!off[0]) begin
                ct_latch_next[off[3:1]] =
                  ct_count[off[3:1]*CT_W +: CT_W]; // [RULE14]
                sample_data_next = ct_count[off[3:1]*CT_W +: SAMPLE_W];
              end else begin
                sample_data_next =
                  ct_latch_reg[off[3:1]][CT_W-1 -: SAMPLE_W]; // [RULE14]
              end
            end
            state_next = single_reg ? ST_IDLE : after_next;
          end
        end
      end
      ST_CONV: begin
        if (conv_done) begin
          sample_valid_next = ~inh_reg; // [RULE4]
          sample_last_next = last_reg;
          sample_data_next = SAMPLE_W'(conv_data); // [RULE11]
          state_next = after_reg;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // stop abandons the scan wherever it stands, and beats a start
    if (scan_stop) begin
      state_next = ST_IDLE;
      conv_start_next = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      after_reg <= ST_IDLE;
      ptr_reg <= '0;
      pace_reg <= '0;
      single_reg <= 1'b0;
      s_chan_reg <= '0;
      s_gain_reg <= '0;
      inh_reg <= 1'b0;
      last_reg <= 1'b0;
      mux_chan <= '0;
      mux_gain <= '0;
      mux_diff <= 1'b0;
      conv_start <= 1'b0;
      dyn_dout <= DYN_DOUT_RST;
      sample_valid <= 1'b0;
      sample_last <= 1'b0;
      sample_data <= '0;
      sample_chan <= '0;
      for (int i = 0; i < NUM_CT; i++) begin
        ct_latch_reg[i] <= '0;
      end
    end else begin
      state_reg <= state_next;
      after_reg <= after_next;
      ptr_reg <= ptr_next;
      pace_reg <= pace_next;
      single_reg <= single_next;
      s_chan_reg <= s_chan_next;
      s_gain_reg <= s_gain_next;
      inh_reg <= inh_next;
      last_reg <= last_next;
      mux_chan <= mux_chan_next;
      mux_gain <= mux_gain_next;
      mux_diff <= mux_diff_next;
      conv_start <= conv_start_next;
      dyn_dout <= dyn_dout_next;
      sample_valid <= sample_valid_next;
      sample_last <= sample_last_next;
      sample_data <= sample_data_next;
      sample_chan <= sample_chan_next;
      for (int i = 0; i < NUM_CT; i++) begin
        ct_latch_reg[i] <= ct_latch_next[i];
      end
    end
  end

  assign busy = (state_reg != ST_IDLE);
endmodule
`default_nettype wire

// *** bench/cgl_conv_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module cgl_conv_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic slow,
  input wire logic conv_start,
  input wire logic [5:0] mux_chan,
  input wire logic [1:0] mux_gain,
  output logic conv_done,
  output logic [15:0] conv_data
);
  logic [5:0] cnt;
  logic pend;
  // answers after 3 or 41 cycles; data marks channel and gain
  always @(posedge clk) begin
    conv_done <= 1'b0;
    if (!rstn) begin
      pend <= 1'b0;
      conv_data <= 16'h0000;
    end else if (conv_start) begin
      pend <= 1'b1;
      cnt <= slow ? 6'h28 : 6'h02;
    end else if (pend && cnt == 6'h00) begin
      pend <= 1'b0;
      conv_done <= 1'b1;
      conv_data <= {mux_chan, mux_gain, 8'h5A};
    end else begin
      cnt <= cnt - 6'h01;
      conv_data <= ~conv_data; // stale data must never look valid
    end
  end
endmodule
`default_nettype wire

// *** bench/ai_channel_gain_list_sequencer_checker.sv ***
`timescale 1ns/10ps
`default_nettype none
module ai_channel_gain_list_sequencer_checker
  import cgl_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic scan_start,
  input wire logic scan_stop,
  input wire logic diff_mode,
  input wire logic dyn_dout_en,
  input wire logic busy,
  input wire logic conv_start,
  input wire logic sample_valid,
  input wire logic mux_diff,
  input wire logic dyn_dout
);
  logic [7:0] gap_reg, gap_next;
  logic seen_reg, seen_next;
  // cycles since last conversion start, forgotten between operations
  always_comb begin
    gap_next = (gap_reg == 8'hFF) ? gap_reg : gap_reg + 8'h01;
    seen_next = busy ? seen_reg : 1'b0;
    if (conv_start) begin
      gap_next = 8'h01;
      seen_next = 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      gap_reg <= 8'h00;
      seen_reg <= 1'b0;
    end else begin
      gap_reg <= gap_next;
      seen_reg <= seen_next;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_idle_start;
    !busy && scan_start && !scan_stop;
  endsequence
  a_start_busy: assert property (s_idle_start |=> busy)
    else $error("scan start not taken");
  a_stop_idle: assert property (scan_stop |=> !busy)
    else $error("stop did not end the scan");
  a_conv_pulse: assert property (conv_start |=> !conv_start)
    else $error("conversion start too long");
  a_valid_pulse: assert property (sample_valid |=> !sample_valid)
    else $error("sample valid too long");
  a_pace_gap: assert property (conv_start && seen_reg |->
    gap_reg >= 8'(PACE_CYC)) else $error("conversions too close");
  a_idle_quiet: assert property (!busy && !$past(scan_stop) |->
    !conv_start) else $error("conversion while idle");
  a_diff_follow: assert property ($past(rstn) |->
    mux_diff == $past(diff_mode)) else $error("mux mode lags wrongly");
  a_dout_hold: assert property ($past(rstn) && !$past(dyn_dout_en) |->
    $stable(dyn_dout)) else $error("dynamic output moved while off");
endmodule
bind ai_channel_gain_list_sequencer ai_channel_gain_list_sequencer_checker
  ai_channel_gain_list_sequencer_checker_inst (.clk(clk), .rstn(rstn),
  .scan_start(scan_start), .scan_stop(scan_stop), .diff_mode(diff_mode),
  .dyn_dout_en(dyn_dout_en), .busy(busy), .conv_start(conv_start),
  .sample_valid(sample_valid), .mux_diff(mux_diff), .dyn_dout(dyn_dout));
`default_nettype wire

// *** bench/ai_channel_gain_list_sequencer_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module ai_channel_gain_list_sequencer_tb_top;
  import cgl_pkg::*;
  logic clk, rstn, list_wr, list_inhibit, list_dout, diff_mode, cont_mode;
  logic dyn_dout_en, scan_start, scan_stop, trig_in, single_req, slow;
  logic mux_diff, conv_start, conv_done, sample_valid, sample_last, busy;
  logic dyn_dout;
  logic [PTR_W-1:0] list_addr;
  logic [CHAN_W-1:0] list_chan, single_chan, mux_chan, sample_chan;
  logic [GAIN_W-1:0] list_gain, single_gain, mux_gain;
  logic [LEN_W-1:0] list_len;
  logic [DIN_W-1:0] din;
  logic [NUM_CT*CT_W-1:0] ct_count;
  logic [15:0] conv_data, sample_data;
  int n_fail, cmp_count, waited;
  ai_channel_gain_list_sequencer ai_channel_gain_list_sequencer_inst (
    .clk(clk), .rstn(rstn), .list_wr(list_wr), .list_addr(list_addr),
    .list_chan(list_chan), .list_gain(list_gain), .list_inhibit(list_inhibit),
    .list_dout(list_dout), .list_len(list_len), .diff_mode(diff_mode),
    .cont_mode(cont_mode), .dyn_dout_en(dyn_dout_en), .trig_in(trig_in),
    .scan_start(scan_start), .scan_stop(scan_stop), .single_req(single_req),
    .single_chan(single_chan), .single_gain(single_gain), .din(din),
    .ct_count(ct_count), .mux_chan(mux_chan), .mux_gain(mux_gain),
    .mux_diff(mux_diff), .conv_start(conv_start), .conv_done(conv_done),
    .conv_data(conv_data), .sample_valid(sample_valid), .busy(busy),
    .sample_data(sample_data), .sample_chan(sample_chan),
    .sample_last(sample_last), .dyn_dout(dyn_dout));
  cgl_conv_model cgl_conv_model_inst (.clk(clk), .rstn(rstn), .slow(slow),
    .conv_start(conv_start), .mux_chan(mux_chan), .mux_gain(mux_gain),
    .conv_done(conv_done), .conv_data(conv_data));
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [5:0] c,
      input logic [1:0] g, input logic i, input logic d);
    @(negedge clk);
    {list_wr, list_addr, list_chan, list_gain, list_inhibit, list_dout} =
      {1'b1, a, c, g, i, d};
    @(negedge clk);
    list_wr = 1'b0;
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  // bounded wait for one kept sample, then judge channel and data
  task automatic get(input logic [5:0] c, input logic [15:0] d);
    waited = 0;
    do begin
      @(negedge clk);
      waited++;
    end while (sample_valid !== 1'b1 && waited < 400);
    // a sample that never came counts as a mismatch here
    chk("sample valid", 16'h0001, {15'h0000, sample_valid});
    chk("sample chan", {10'h000, c}, {10'h000, sample_chan});
    chk("sample data", d, sample_data);
  endtask
  task automatic quiet(input int n);
    int k;
    k = 0;
    repeat (n) begin
      @(negedge clk);
      if (sample_valid !== 1'b0) k++;
    end
    chk("extra samples", 16'h0000, k[15:0]);
  endtask
  task automatic stop_chk();
    pulse(scan_stop);
    chk("busy", 16'h0000, {15'h0000, busy});
  endtask
  task automatic t_list();
    wr(10'h000, 6'h05, 2'h1, 1'b0, 1'b0);
    wr(10'h001, 6'h20, 2'h0, 1'b0, 1'b1);
    wr(10'h002, 6'h05, 2'h2, 1'b1, 1'b1);
    wr(10'h003, 6'h03, 2'h3, 1'b0, 1'b1);
    {list_len, cont_mode, dyn_dout_en} = {11'h004, 1'b1, 1'b1};
    pulse(scan_start);
    chk("busy", 16'h0001, {15'h0000, busy});
    get(6'h05, 16'h155A);
    get(6'h20, 16'hBEEF);
    chk("dout", 16'h0001, {15'h0000, dyn_dout});
    get(6'h03, 16'h0F5A);
    chk("last", 16'h0001, {15'h0000, sample_last});
    get(6'h05, 16'h155A);
    chk("dout", 16'h0000, {15'h0000, dyn_dout});
    stop_chk();
  endtask
  // triggered pass of one digital entry, one pass per trigger
  task automatic t_trig();
    wr(10'h000, 6'h20, 2'h0, 1'b0, 1'b0);
    // top slot written too; entry 0 must come back untouched
    wr(10'h3FF, 6'h05, 2'h0, 1'b0, 1'b0);
    {list_len, cont_mode} = {11'h001, 1'b0};
    pulse(scan_start);
    repeat (2) begin
      din = ~din;
      pulse(trig_in);
      get(6'h20, din);
      chk("last", 16'h0001, {15'h0000, sample_last});
      quiet(200);
    end
    stop_chk();
  endtask
  task automatic sgl(input logic [5:0] c, input logic [15:0] d);
    @(negedge clk);
    {single_req, single_chan, single_gain} = {1'b1, c, 2'h2};
    @(negedge clk);
    single_req = 1'b0;
    get(c, d);
    @(negedge clk);
    chk("busy", 16'h0000, {15'h0000, busy});
  endtask
  task automatic t_ct();
    // entry out bits set while dynamic output is off: line must hold
    wr(10'h000, 6'h21, 2'h0, 1'b0, 1'b1);
    wr(10'h001, 6'h22, 2'h0, 1'b0, 1'b1);
    {list_len, cont_mode, dyn_dout_en} = {11'h002, 1'b1, 1'b0};
    pulse(scan_start);
    get(6'h21, 16'h5678);
    ct_count[31:0] = 32'hAAAA_0000;
    get(6'h22, 16'h1234);
    chk("gap", 16'(PACE_CYC), waited[15:0]);
    chk("dout", 16'h0000, {15'h0000, dyn_dout});
    stop_chk();
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    {rstn, list_wr, list_inhibit, list_dout, diff_mode, cont_mode} = '0;
    {dyn_dout_en, scan_start, scan_stop, trig_in, single_req, slow} = '0;
    {list_addr, list_chan, list_gain, single_chan, single_gain} = '0;
    {list_len, din} = {11'h001, 16'hBEEF};
    ct_count = {128'h0, 32'h1234_5678};
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    t_list();
    t_trig();
    {slow, diff_mode} = 2'b11;
    sgl(6'h0F, 16'h3E5A);
    sgl(6'h14, 16'h0000);
    {slow, diff_mode} = 2'b00;
    sgl(6'h14, 16'h525A);
    t_ct();
    print_verdict();
  end
  // watchdog: whole run needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    print_verdict();
  end
endmodule
`default_nettype wire
